// *** verilog/change_detect_pkg.sv ***
// shared constants and types for the data change detector debounce control
package change_detect_pkg;

  localparam int          DATA_W   = 12;
  localparam int          CNT_W    = 8;
  localparam int          ADDR_W   = 8;

  // register byte addresses
  localparam logic [7:0]  ADDR_CONFIG2     = 8'h30;
  localparam logic [7:0]  ADDR_OUTSIDE_LIM = 8'h31;
  localparam logic [7:0]  ADDR_INSIDE_LIM  = 8'h32;

  // control register field positions
  localparam int          BIT_ENABLE       = 7;
  localparam int          BIT_POLICY_HI    = 6;
  localparam int          BIT_POLICY_LO    = 5;
  localparam int          BIT_OUTSIDE_MODE = 4;
  localparam int          BIT_INSIDE_MODE  = 3;
  localparam int          BIT_COMBINE      = 2;
  localparam int          BIT_SOURCE       = 1;
  localparam int          BIT_REFRESH      = 0;

  // reset values
  localparam logic [7:0]  CONFIG2_RST      = 8'h00;
  localparam logic [7:0]  LIMIT_RST        = 8'h00;
  localparam logic [11:0] REF_ZERO         = 12'h000;

  // reference refresh policies
  localparam logic [1:0]  POLICY_FOLLOW_EVENT = 2'h0;
  localparam logic [1:0]  POLICY_HOLD         = 2'h1;
  localparam logic [1:0]  POLICY_SLOPE        = 2'h2;
  localparam logic [1:0]  POLICY_ABSOLUTE     = 2'h3;

  // operating modes, used to pick the counter time step
  typedef enum logic [1:0] {
    OP_LOW_POWER        = 2'h0,
    OP_HIGH_PERFORMANCE = 2'h1,
    OP_FLEXIBLE         = 2'h2
  } op_mode_t;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } triplet_t;

  typedef struct packed {
    logic        enable;
    logic [1:0]  policy;
    logic        outside_mode;
    logic        inside_mode;
    logic        combine;
    logic        source;
    logic        refresh;
  } config2_t;

endpackage

// *** verilog/debounce_counter.sv ***
// one debounce counter with its event flag
module debounce_counter #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             step,
  input  wire logic             cond,
  input  wire logic             clear_mode,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  flag,
  output logic                  rise
);

  logic [CNT_W-1:0] cnt_r;
  logic             flag_r;

  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      cnt_r  <= '0;
      flag_r <= 1'b0;
    end else if (step) begin
      if (cond) begin
        if (cnt_r < limit) begin
          cnt_r <= cnt_r + 1'b1;
        end
        if (cnt_r + 1'b1 >= limit || cnt_r >= limit) begin
          flag_r <= 1'b1; // [R18] [R13] [R14]
        end
      end else if (clear_mode) begin
        cnt_r  <= '0; // [R3] [R16]
        flag_r <= 1'b0;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1; // [R1] [R16]
      end else begin
        // limit decrements plus this one: limit+1 false periods
        flag_r <= 1'b0; // [R2]
      end
    end
  end

  logic flag_d_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_d_r <= 1'b0;
    end else begin
      flag_d_r <= flag_r;
    end
  end

  assign flag = flag_r;
  assign rise = flag_r & ~flag_d_r;

endmodule

// *** verilog/change_detect_debounce_ctrl.sv ***
// debounce, axis combine, input select and reference refresh for the change detector
// Function
// (R1) mode 0: inside counter decrements on false
// (R2) flag re-arms after limit+1 false periods
// (R3) mode 1: inside counter clears on false
// (R4) combine select: 0 AND, 1 OR
// (R5) source 1: magnitude on X only
// (R6) software enables magnitude calc with source 1
// (R7) refresh request loads references from data
// (R8) absolute policy keeps references at zero
// (R9) reference load waits up to one sample
// (R10) refresh bit self-clears after load
// (R11) refresh bit writable in any state
// (R12) counters step per sample or effective period
// (R13) outside limit sets outside event count
// (R14) inside limit sets inside event count
// (R15) state changes reset both counters
// (R16) outside counter mode mirrors inside counter
// (R17) hold policy keeps captured reference until refresh
// (R18) flag sets when count reaches limit
module change_detect_debounce_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire change_detect_pkg::op_mode_t op_mode,
  input  wire logic                        op_active,
  input  wire logic                        wake_sleep_change,
  input  wire logic                        sample_tick,
  input  wire logic                        effective_tick,
  input  wire change_detect_pkg::triplet_t accel,
  input  wire logic [11:0]                 magnitude,
  input  wire logic [2:0]                  inside_axis_en,
  input  wire logic [2:0]                  outside_axis_en,
  input  wire logic [2:0]                  inside_axis_hit,
  input  wire logic [2:0]                  outside_axis_hit,
  output change_detect_pkg::triplet_t      compare_data,
  output logic      [2:0]                  compare_axis_used,
  output change_detect_pkg::triplet_t      reference,
  output logic                             inside_event,
  output logic                             outside_event,
  output logic                             inside_rise,
  output logic                             outside_rise
);

  change_detect_pkg::config2_t cfg_r;
  logic [7:0]                  outside_lim_r;
  logic [7:0]                  inside_lim_r;
  logic                        refresh_done;
  logic                        step;
  logic                        active_d_r;
  logic                        enable_d_r;
  logic                        first_pending_r;
  logic                        state_change;
  logic [2:0]                  used;
  logic [2:0]                  in_hit;
  logic [2:0]                  out_hit;
  logic                        inside_cond;
  logic                        outside_cond;
  logic                        cfg_wr;

  assign cfg_wr = reg_wr && (reg_addr == change_detect_pkg::ADDR_CONFIG2);

  // register writes; a new refresh request beats the self-clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r         <= change_detect_pkg::CONFIG2_RST;
      outside_lim_r <= change_detect_pkg::LIMIT_RST;
      inside_lim_r  <= change_detect_pkg::LIMIT_RST;
    end else begin
      if (cfg_wr) begin
        cfg_r <= reg_wdata;
        cfg_r.refresh <= reg_wdata[change_detect_pkg::BIT_REFRESH] | // [R11]
                         (cfg_r.refresh & ~refresh_done);
      end else if (refresh_done) begin
        cfg_r.refresh <= 1'b0; // [R10]
      end
      if (reg_wr && reg_addr == change_detect_pkg::ADDR_OUTSIDE_LIM) begin
        outside_lim_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == change_detect_pkg::ADDR_INSIDE_LIM) begin
        inside_lim_r <= reg_wdata;
      end
    end
  end

  // read data registered, unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        change_detect_pkg::ADDR_CONFIG2:     reg_rdata <= cfg_r;
        change_detect_pkg::ADDR_OUTSIDE_LIM: reg_rdata <= outside_lim_r;
        change_detect_pkg::ADDR_INSIDE_LIM:  reg_rdata <= inside_lim_r;
        default:                             reg_rdata <= 8'h00;
      endcase
    end
  end

  // time step choice
  assign step = (op_mode == change_detect_pkg::OP_FLEXIBLE) ? effective_tick
                                                            : sample_tick; // [R12]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_d_r <= 1'b0;
      enable_d_r <= 1'b0;
    end else begin
      active_d_r <= op_active;
      enable_d_r <= cfg_r.enable;
    end
  end

  assign state_change = (op_active ^ active_d_r) | wake_sleep_change; // [R15]

  // input source select: magnitude mode drops Y and Z
  always_comb begin
    if (cfg_r.source) begin
      compare_data = '{x: magnitude, y: 12'h000, z: 12'h000}; // [R5]
      used         = 3'h4;
    end else begin
      compare_data = accel;
      used         = 3'h7;
    end
  end

  assign compare_axis_used = used;
  assign in_hit            = inside_axis_hit | ~(inside_axis_en & used);
  assign out_hit           = outside_axis_hit & outside_axis_en & used;

  // with no axis enabled neither condition can be true
  always_comb begin
    if ((inside_axis_en & used) == 3'h0) begin
      inside_cond = 1'b0;
    end else if (cfg_r.combine) begin
      inside_cond = |(inside_axis_hit & inside_axis_en & used); // [R4]
    end else begin
      inside_cond = &in_hit; // [R4]
    end
  end

  assign outside_cond = |out_hit;

  debounce_counter #(
    .CNT_W (change_detect_pkg::CNT_W)
  ) u_inside (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clear      (state_change || !cfg_r.enable), // [R15]
    .step       (step),
    .cond       (inside_cond),
    .clear_mode (cfg_r.inside_mode),
    .limit      (inside_lim_r), // [R14]
    .flag       (inside_event),
    .rise       (inside_rise)
  );

  debounce_counter #(
    .CNT_W (change_detect_pkg::CNT_W)
  ) u_outside (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .clear      (state_change || !cfg_r.enable), // [R15]
    .step       (step),
    .cond       (outside_cond),
    .clear_mode (cfg_r.outside_mode), // [R16]
    .limit      (outside_lim_r), // [R13]
    .flag       (outside_event),
    .rise       (outside_rise)
  );

  // first capture after enable waits for the next step (sample tick, or effective tick in flexible mode)
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_pending_r <= 1'b0;
    end else if (cfg_r.enable && !enable_d_r) begin
      first_pending_r <= 1'b1;
    end else if (step || !cfg_r.enable) begin
      first_pending_r <= 1'b0;
    end
  end

  // refresh is aligned to the counter step (sample tick, or effective tick in flexible mode), so it lands within one period
  assign refresh_done = cfg_r.refresh && step; // [R9]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reference <= '{x: change_detect_pkg::REF_ZERO, y: change_detect_pkg::REF_ZERO,
                     z: change_detect_pkg::REF_ZERO};
    end else if (cfg_r.policy == change_detect_pkg::POLICY_ABSOLUTE) begin
      reference <= '{x: change_detect_pkg::REF_ZERO, y: change_detect_pkg::REF_ZERO,
                     z: change_detect_pkg::REF_ZERO}; // [R8]
    end else if (step && (cfg_r.refresh || first_pending_r)) begin
      reference <= compare_data; // [R7] [R17]
    end else if (step && cfg_r.enable
                 && cfg_r.policy == change_detect_pkg::POLICY_SLOPE) begin
      reference <= compare_data;
    end else if (outside_rise
                 && cfg_r.policy == change_detect_pkg::POLICY_FOLLOW_EVENT) begin
      reference <= compare_data;
    end
  end

endmodule

// *** tb/change_detect_properties.sv ***
// port assertions for the change detector debounce control
module change_detect_properties (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic [7:0]                  reg_addr,
  input wire logic                        reg_wr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata,
  input wire change_detect_pkg::op_mode_t op_mode,
  input wire logic                        sample_tick,
  input wire logic                        effective_tick,
  input wire change_detect_pkg::triplet_t accel,
  input wire logic [11:0]                 magnitude,
  input wire change_detect_pkg::triplet_t compare_data,
  input wire logic [2:0]                  compare_axis_used,
  input wire change_detect_pkg::triplet_t reference,
  input wire logic                        inside_event,
  input wire logic                        outside_event,
  input wire logic                        inside_rise,
  input wire logic                        outside_rise
);
  logic [7:0] cfg_r;
  logic       step;

  assign step = (op_mode == change_detect_pkg::OP_FLEXIBLE) ? effective_tick : sample_tick;

  // shadow of the control byte, the block's own copy is hidden
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h30) begin
      cfg_r <= reg_wdata;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // rise is decoded from the flag registers, so it stands in the flag's first high cycle
  a_inside_rise_pulse: assert property (inside_rise == $rose(inside_event))
    else $error("inside rise pulse wrong");
  a_outside_rise_pulse: assert property (outside_rise == $rose(outside_event))
    else $error("outside rise pulse wrong");
  a_inside_on_step: assert property ($rose(inside_event) |-> $past(step))
    else $error("inside flag set without a step");
  a_outside_on_step: assert property ($rose(outside_event) |-> $past(step))
    else $error("outside flag set without a step");
  a_inside_limit_rb: assert property (reg_wr && reg_addr == 8'h32 ##1 !reg_wr ##1
    reg_rd && reg_addr == 8'h32 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("inside limit readback wrong");
  a_outside_limit_rb: assert property (reg_wr && reg_addr == 8'h31 ##1 !reg_wr ##1
    reg_rd && reg_addr == 8'h31 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("outside limit readback wrong");
  a_magnitude_route: assert property (cfg_r[1] |->
    compare_data == {magnitude, 24'h000000} && compare_axis_used == 3'h4)
    else $error("magnitude routing wrong");
  a_axis_route: assert property (!cfg_r[1] |->
    compare_data == accel && compare_axis_used == 3'h7)
    else $error("axis routing wrong");
  a_hold_reference: assert property (cfg_r[6:5] == 2'h1 && $stable(cfg_r) && !reg_wr
    && !step |=> $stable(reference))
    else $error("held reference moved");
  a_absolute_zero: assert property (cfg_r[6:5] == 2'h3 && $stable(cfg_r)
    |=> reference == 36'h0)
    else $error("absolute reference not zero");
endmodule

bind change_detect_debounce_ctrl change_detect_properties u_props (
  .clk_sys           (clk_sys),
  .rst               (rst),
  .reg_addr          (reg_addr),
  .reg_wr            (reg_wr),
  .reg_wdata         (reg_wdata),
  .reg_rd            (reg_rd),
  .reg_rdata         (reg_rdata),
  .op_mode           (op_mode),
  .sample_tick       (sample_tick),
  .effective_tick    (effective_tick),
  .accel             (accel),
  .magnitude         (magnitude),
  .compare_data      (compare_data),
  .compare_axis_used (compare_axis_used),
  .reference         (reference),
  .inside_event      (inside_event),
  .outside_event     (outside_event),
  .inside_rise       (inside_rise),
  .outside_rise      (outside_rise)
);

// *** tb/change_detect_debounce_ctrl_bench.sv ***
// random self-checking bench for the change detector debounce control
`define check_eq(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module change_detect_debounce_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        clk_sys, rst, reg_wr, reg_rd, op_active, wake_sleep_change;
  logic                        sample_tick, effective_tick, inside_event, outside_event;
  logic                        inside_rise, outside_rise, flag_i, flag_o;
  logic                        p_clr, p_step, p_ci, p_co;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata, cfg;
  logic [11:0]                 magnitude;
  logic [2:0]                  inside_axis_en, outside_axis_en, inside_axis_hit, outside_axis_hit;
  logic [2:0]                  compare_axis_used;
  logic [63:0]                 r64;
  change_detect_pkg::op_mode_t op_mode;
  change_detect_pkg::triplet_t accel, compare_data, reference, t;
  int                          bad_count, check_count, lim_i, lim_o, cnt_i, cnt_o;

  change_detect_debounce_ctrl u_dut (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_wdata         (reg_wdata),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .op_mode           (op_mode),
    .op_active         (op_active),
    .wake_sleep_change (wake_sleep_change),
    .sample_tick       (sample_tick),
    .effective_tick    (effective_tick),
    .accel             (accel),
    .magnitude         (magnitude),
    .inside_axis_en    (inside_axis_en),
    .outside_axis_en   (outside_axis_en),
    .inside_axis_hit   (inside_axis_hit),
    .outside_axis_hit  (outside_axis_hit),
    .compare_data      (compare_data),
    .compare_axis_used (compare_axis_used),
    .reference         (reference),
    .inside_event      (inside_event),
    .outside_event     (outside_event),
    .inside_rise       (inside_rise),
    .outside_rise      (outside_rise)
  );

  function automatic void debounce(input logic c, input logic m, input int lim,
                                   inout int cnt, inout logic f);
    if (c) begin
      if (cnt + 1 >= lim) f = 1'b1;
      if (cnt < lim) cnt++;
    end else if (m) begin
      cnt = 0;
      f = 1'b0;
    end else if (cnt != 0) begin
      cnt--;
    end else begin
      f = 1'b0;
    end
  endfunction

  function automatic logic in_cond(input logic [2:0] en, input logic [2:0] hit,
                                   input logic or_sel);
    return en != 3'h0 && (or_sel ? |(hit & en) : (hit & en) == en);
  endfunction

  function automatic change_detect_pkg::triplet_t rnd_t();
    logic [63:0] v;
    v = {$urandom, $urandom};
    return v[35:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `check_eq(reg_rdata, e)
  endtask

  task automatic tick(input change_detect_pkg::triplet_t a);
    @(posedge clk_sys);
    accel <= a;
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // whole run is about 2000 cycles, so this leaves a wide margin
  initial begin
    #(25 * 20000);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    op_active = 1'b1;
    op_mode = change_detect_pkg::OP_LOW_POWER;
    {reg_wr, reg_rd, wake_sleep_change, sample_tick, effective_tick} = 5'h00;
    {reg_addr, reg_wdata, magnitude, accel} = '0;
    {inside_axis_en, outside_axis_en, inside_axis_hit, outside_axis_hit} = 12'h000;
    bad_count = 0;
    check_count = 0;
    void'($urandom(79));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(8'h31, 8'h00);
    rdchk(8'h32, 8'h00);
    rdchk(8'h5C, 8'h00);
    wr(8'h30, 8'hA0);
    t = rnd_t();
    tick(t);
    `check_eq(reference, t)
    @(posedge clk_sys);
    op_active <= 1'b0;
    wr(8'h30, 8'hA1);
    rdchk(8'h30, 8'hA1);
    t = rnd_t();
    tick(t);
    `check_eq(reference, t)
    rdchk(8'h30, 8'hA0);
    tick(rnd_t());
    `check_eq(reference, t)
    wr(8'h30, 8'hE1);
    tick(t);
    `check_eq(reference, 36'h0)
    rdchk(8'h30, 8'hE0);
    repeat (12) begin
      // magnitude calc is taken as enabled elsewhere whenever the source bit is set
      cfg = 8'($urandom) & 8'h7E;
      lim_i = $urandom_range(4, 0);
      lim_o = $urandom_range(4, 0);
      wr(8'h30, cfg);
      wr(8'h31, 8'(lim_o));
      rdchk(8'h31, 8'(lim_o));
      wr(8'h32, 8'(lim_i));
      rdchk(8'h32, 8'(lim_i));
      @(posedge clk_sys);
      op_mode <= change_detect_pkg::op_mode_t'($urandom_range(2, 0));
      inside_axis_en <= cfg[1] ? 3'h4 : 3'($urandom);
      outside_axis_en <= cfg[1] ? 3'h4 : 3'($urandom);
      wr(8'h30, cfg | 8'h80);
      {cnt_i, cnt_o, flag_i, flag_o, p_clr, p_step} = '0;
      repeat (150) begin
        @(posedge clk_sys);
        r64 = {$urandom, $urandom};
        // no step in a cycle that resets the counters, the order would be ambiguous
        sample_tick <= r64[0] && r64[9:5] != 5'h00;
        effective_tick <= r64[1] && r64[9:5] != 5'h00;
        wake_sleep_change <= r64[2] && r64[9:5] == 5'h00;
        if (!r64[2] && r64[9:5] == 5'h00) op_active <= !op_active;
        inside_axis_hit <= r64[12:10];
        outside_axis_hit <= r64[15:13];
        accel <= r64[63:28];
        magnitude <= r64[27:16];
        @(negedge clk_sys);
        if (p_clr) begin
          {cnt_i, cnt_o, flag_i, flag_o} = '0;
        end else if (p_step) begin
          debounce(p_ci, cfg[3], lim_i, cnt_i, flag_i);
          debounce(p_co, cfg[4], lim_o, cnt_o, flag_o);
        end
        `check_eq(inside_event, flag_i)
        `check_eq(outside_event, flag_o)
        p_clr = r64[9:5] == 5'h00;
        p_step = (op_mode == change_detect_pkg::OP_FLEXIBLE) ? r64[1] : r64[0];
        p_ci = in_cond(inside_axis_en, r64[12:10], cfg[2]);
        p_co = |(outside_axis_en & r64[15:13]);
      end
      @(posedge clk_sys);
      {sample_tick, effective_tick, wake_sleep_change} <= 3'h0;
    end
    give_verdict();
  end
endmodule
